// ==== hdl/slg_defines.vh ====
`ifndef SLG_DEFINES_VH
`define SLG_DEFINES_VH

// ==========================================================
// Register byte offsets
`define SLG_OFF_SPD_GAIN_A 8'h00
`define SLG_OFF_SPD_INTEG_A 8'h04
`define SLG_OFF_POS_GAIN_A 8'h08
`define SLG_OFF_INERTIA 8'h0c
`define SLG_OFF_SPD_GAIN_B 8'h10
`define SLG_OFF_SPD_INTEG_B 8'h14
`define SLG_OFF_POS_GAIN_B 8'h18
`define SLG_OFF_BIAS_SPEED 8'h1c
`define SLG_OFF_BIAS_BAND 8'h20
`define SLG_OFF_FF_AMOUNT 8'h24
`define SLG_OFF_FF_FILTER 8'h28
`define SLG_OFF_SPD_CTRL 8'h2c
`define SLG_OFF_STATUS 8'h30
`define SLG_NUM_PARAMS 12

// ==========================================================
// Reset values
`define SLG_RST_SPD_GAIN 16'h0320
`define SLG_RST_SPD_INTEG 16'h07d0
`define SLG_RST_POS_GAIN 16'h0190
`define SLG_RST_INERTIA 16'h012c
`define SLG_RST_BIAS_SPEED 16'h0000
`define SLG_RST_BIAS_BAND 16'h0007
`define SLG_RST_FF_AMOUNT 16'h0000
`define SLG_RST_FF_FILTER 16'h0000
`define SLG_RST_SPD_CTRL 16'h0004

// ==========================================================
// Legal ranges
`define SLG_MIN_GAIN 16'h000a
`define SLG_MAX_GAIN 16'h4e20
`define SLG_MIN_INTEG 16'h000f
`define SLG_MAX_INTEG 16'hc800
`define SLG_MAX_INERTIA 16'h4e20
`define SLG_MAX_BIAS_SPEED 16'h01c2
`define SLG_MAX_BIAS_BAND 16'h00fa
`define SLG_MAX_FF_AMOUNT 16'h0064
`define SLG_MAX_FF_FILTER 16'h1900
`define SLG_MAX_PCTL_COND 4'h4

// ==========================================================
// Field positions and codes
`define SLG_PCTL_LSB 0
`define SLG_PCTL_MSB 3
`define SLG_PCTL_DEVIATION 4'h3
`define SLG_PCTL_NONE 4'h4
`define SLG_ST_SET_B 0
`define SLG_ST_BIAS_ON 1
`define SLG_ST_POS_MODE 2
`define SLG_ST_SWITCH_REQ 3

// ==========================================================
// Timing: filter step is the 0.01 ms unit of the lag constant
`define SLG_FF_STEP_NS 10000
`define SLG_CLK_PERIOD_NS 10
`define SLG_FF_STEP_CYC (`SLG_FF_STEP_NS / `SLG_CLK_PERIOD_NS)

`endif

// ==== hdl/slg_servo_gain.v ====
// Functional notes
// - speed loop gain 10..20000, default 800
// - speed integral constant 15..51200, default 2000
// - position loop gain 10..20000, default 400
// - steady deviation equals command rate over gain
// - inertia ratio percent 0..20000, default 300
// - second gain set, selected on switching
// - gain switching only in position control
// - bias speed 0..450, band 0..250 default 7
// - add bias while deviation exceeds band
// - feed-forward percent 0..100, default 0
// - feed-forward first-order lag, 0..6400 units
// - control word default 0004, digit 0..4
// - condition codes torque, speed, accel, deviation, none
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`include "slg_defines.vh"

module slg_servo_gain #(
  parameter FF_STEP_CYC = `SLG_FF_STEP_CYC
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // AXI4-Lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Control loop inputs
  input wire position_mode,
  input wire gain_switch_pin,
  input wire signed [31:0] deviation,
  input wire signed [31:0] cmd_rate,
  // Active loop parameters
  output reg [15:0] speed_loop_gain,
  output reg [15:0] speed_loop_integ,
  output reg [15:0] position_loop_gain,
  output reg [15:0] inertia_ratio,
  output reg gain_set_b,
  // Bias, feed-forward and expected deviation
  output reg signed [15:0] bias_add,
  output reg signed [31:0] ff_cmd,
  output reg signed [31:0] expected_deviation,
  // P-control switching condition, at most one set (none for code 4)
  output reg pctl_by_torque,
  output reg pctl_by_speed,
  output reg pctl_by_accel,
  output reg pctl_by_deviation
);

  localparam [1:0] RESP_OKAY = 2'b00;
  localparam [1:0] RESP_SLVERR = 2'b10;

  // ========================================================
  // Parameter store
  reg [15:0] prm [0:`SLG_NUM_PARAMS-1];
  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;

  function [15:0] prm_default;
    input [3:0] idx;
    begin
      case (idx)
        4'd0, 4'd4: prm_default = `SLG_RST_SPD_GAIN;
        4'd1, 4'd5: prm_default = `SLG_RST_SPD_INTEG;
        4'd2, 4'd6: prm_default = `SLG_RST_POS_GAIN;
        4'd3: prm_default = `SLG_RST_INERTIA;
        4'd7: prm_default = `SLG_RST_BIAS_SPEED;
        4'd8: prm_default = `SLG_RST_BIAS_BAND;
        4'd9: prm_default = `SLG_RST_FF_AMOUNT;
        4'd10: prm_default = `SLG_RST_FF_FILTER;
        default: prm_default = `SLG_RST_SPD_CTRL;
      endcase
    end
  endfunction

  // Out-of-range writes saturate to the nearest legal value
  function [15:0] prm_clamp;
    input [3:0] idx;
    input [15:0] v;
    reg [15:0] lo;
    reg [15:0] hi;
    begin
      lo = 16'h0000;
      hi = 16'hffff;
      case (idx)
        4'd0, 4'd2, 4'd4, 4'd6:
        begin
          lo = `SLG_MIN_GAIN;
          hi = `SLG_MAX_GAIN;
        end
        4'd1, 4'd5:
        begin
          lo = `SLG_MIN_INTEG;
          hi = `SLG_MAX_INTEG;
        end
        4'd3: hi = `SLG_MAX_INERTIA;
        4'd7: hi = `SLG_MAX_BIAS_SPEED;
        4'd8: hi = `SLG_MAX_BIAS_BAND;
        4'd9: hi = `SLG_MAX_FF_AMOUNT;
        4'd10: hi = `SLG_MAX_FF_FILTER;
        default: ;
      endcase
      if (v < lo)
        prm_clamp = lo;
      else if (v > hi)
        prm_clamp = hi;
      else
        prm_clamp = v;
      if (idx == 4'd11 && v[`SLG_PCTL_MSB:`SLG_PCTL_LSB] >
          `SLG_MAX_PCTL_COND)
        prm_clamp = {v[15:4], `SLG_MAX_PCTL_COND};
    end
  endfunction

  // ========================================================
  // Write channel
  wire [3:0] w_idx = aw_addr[5:2];
  wire w_hit = (aw_addr[7:6] == 2'b00) && (aw_addr[1:0] == 2'b00) &&
    (w_idx < `SLG_NUM_PARAMS);
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire [15:0] old_val = prm[w_idx];
  wire [15:0] merged = {w_strb[1] ? w_data[15:8] : old_val[15:8],
    w_strb[0] ? w_data[7:0] : old_val[7:0]};
  integer i;

  always @(posedge clk)
  begin
    if (srst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      for (i = 0; i < `SLG_NUM_PARAMS; i = i + 1)
        prm[i] <= prm_default(i[3:0]);
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_hit ? RESP_OKAY : RESP_SLVERR;
        if (w_hit)
          prm[w_idx] <= prm_clamp(w_idx, merged);
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ========================================================
  // Gain switch pin synchroniser
  reg sw_s1;
  reg sw_s2;
  reg sw_s3;
  reg switch_req;

  always @(posedge clk)
  begin
    if (srst)
    begin
      sw_s1 <= 1'b0;
      sw_s2 <= 1'b0;
      sw_s3 <= 1'b0;
      switch_req <= 1'b0;
    end
    else
    begin
      sw_s1 <= gain_switch_pin;
      sw_s2 <= sw_s1;
      sw_s3 <= sw_s2;
      if (sw_s2 == sw_s3)
        switch_req <= sw_s3;
    end
  end

  // ========================================================
  // Read channel
  wire [3:0] r_idx = s_axi_araddr[5:2];
  wire r_prm = (s_axi_araddr[7:6] == 2'b00) &&
    (s_axi_araddr[1:0] == 2'b00) && (r_idx < `SLG_NUM_PARAMS);
  wire [31:0] status_word = {28'h0000000, switch_req, position_mode,
    (bias_add != 16'sh0000), gain_set_b};

  always @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (r_prm)
      begin
        s_axi_rdata <= {16'h0000, prm[r_idx]};
        s_axi_rresp <= RESP_OKAY;
      end
      else if (s_axi_araddr == `SLG_OFF_STATUS)
      begin
        s_axi_rdata <= status_word;
        s_axi_rresp <= RESP_OKAY;
      end
      else
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ========================================================
  // Gain set selection and P-control condition
  wire use_b = position_mode && switch_req;
  wire [3:0] pctl_cond =
    prm[11][`SLG_PCTL_MSB:`SLG_PCTL_LSB];

  always @(posedge clk)
  begin
    if (srst)
    begin
      gain_set_b <= 1'b0;
      speed_loop_gain <= `SLG_RST_SPD_GAIN;
      speed_loop_integ <= `SLG_RST_SPD_INTEG;
      position_loop_gain <= `SLG_RST_POS_GAIN;
      inertia_ratio <= `SLG_RST_INERTIA;
      pctl_by_torque <= 1'b0;
      pctl_by_speed <= 1'b0;
      pctl_by_accel <= 1'b0;
      pctl_by_deviation <= 1'b0;
    end
    else
    begin
      gain_set_b <= use_b;
      speed_loop_gain <= use_b ? prm[4] : prm[0];
      speed_loop_integ <= use_b ? prm[5] : prm[1];
      position_loop_gain <= use_b ? prm[6] : prm[2];
      inertia_ratio <= prm[3];
      pctl_by_torque <= (pctl_cond == 4'h0);
      pctl_by_speed <= (pctl_cond == 4'h1);
      pctl_by_accel <= (pctl_cond == 4'h2);
      pctl_by_deviation <= (pctl_cond == `SLG_PCTL_DEVIATION) &&
        position_mode;
    end
  end

  // ========================================================
  // Position bias
  wire [31:0] dev_abs = deviation[31] ? (32'h00000000 - deviation) :
    deviation;
  wire outside_band = dev_abs > {16'h0000, prm[8]};
  wire signed [15:0] bias_mag = prm[7];

  always @(posedge clk)
  begin
    if (srst)
      bias_add <= 16'sh0000;
    else if (position_mode && outside_band)
      bias_add <= deviation[31] ? -bias_mag : bias_mag;
    else
      bias_add <= 16'sh0000;
  end

  // ========================================================
  // Feed-forward with first-order lag
  wire signed [47:0] ff_prod = cmd_rate * $signed({1'b0, prm[9]});
  wire signed [47:0] ff_scaled = ff_prod / 48'sd100;
  wire signed [31:0] ff_target = position_mode ? ff_scaled[31:0] :
    32'sh00000000;
  wire signed [32:0] ff_err = {ff_target[31], ff_target} -
    {ff_cmd[31], ff_cmd};
  wire signed [32:0] ff_div = $signed({16'h0000, prm[10]}) + 33'sd1;
  wire signed [32:0] ff_step = ff_err / ff_div;
  reg [15:0] step_cnt;
  wire step_tick = (step_cnt == FF_STEP_CYC[15:0] - 16'h0001);

  always @(posedge clk)
  begin
    if (srst)
    begin
      step_cnt <= 16'h0000;
      ff_cmd <= 32'sh00000000;
    end
    else
    begin
      step_cnt <= step_tick ? 16'h0000 : step_cnt + 16'h0001;
      if (prm[10] == 16'h0000)
        ff_cmd <= ff_target;
      else if (step_tick)
        ff_cmd <= ff_cmd + ff_step[31:0];
    end
  end

  // ========================================================
  // Expected steady deviation from command rate and gain
  wire signed [47:0] rate_x10 = cmd_rate * 48'sd10;
  wire signed [47:0] exp_q = rate_x10 /
    $signed({32'h00000000, position_loop_gain});

  always @(posedge clk)
  begin
    if (srst)
      expected_deviation <= 32'sh00000000;
    else
      expected_deviation <= exp_q[31:0];
  end

endmodule

// ==== bench/slg_servo_gain_props.sv ====
module slg_props (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Loop side
  input wire logic position_mode,
  input wire logic signed [31:0] deviation,
  input wire logic gain_set_b,
  input wire logic signed [15:0] bias_add,
  input wire logic pctl_by_torque,
  input wire logic pctl_by_speed,
  input wire logic pctl_by_accel,
  input wire logic pctl_by_deviation
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  // ==========================================================
  // Bus timing
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
    else $error("read answer wrong");
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
    ##2 s_axi_bvalid) else $error("write answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response dropped");
  // ==========================================================
  // Loop side
  set_a_only_a: assert property (
    !$past(position_mode) |-> !gain_set_b) else $error("set b outside");
  bias_off_a: assert property (
    !$past(position_mode) |-> bias_add == 16'sh0000)
    else $error("bias outside position");
  bias_sign_a: assert property (
    bias_add != 16'sh0000 |-> (bias_add < 0) == ($past(deviation) < 0))
    else $error("bias sign wrong");
  pctl_onehot_a: assert property (
    $onehot0({pctl_by_deviation, pctl_by_accel, pctl_by_speed,
    pctl_by_torque})) else $error("condition not one-hot");
  pctl_dev_a: assert property (
    pctl_by_deviation |-> $past(position_mode))
    else $error("deviation code outside position");
  cover property (gain_set_b);
  cover property (bias_add != 16'sh0000);
  cover property (pctl_by_deviation);
endmodule

bind slg_servo_gain slg_props slg_props_inst (.*);

// ==== bench/slg_host.sv ====
module slg_host (
  // Clock
  input wire logic clk,
  // Write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  int stall = 0;
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end
  // ==========================================================
  // Bus cycles; stall slows the response side
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
    output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'h3;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_awvalid || s_axi_wvalid);
    repeat (stall) @(posedge clk);
    s_axi_bready <= 1'b1;
    do
      @(posedge clk);
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
      @(posedge clk);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (stall) @(posedge clk);
    s_axi_rready <= 1'b1;
    do
      @(posedge clk);
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ==== bench/tb_servo_loop_gain_bias_ff.sv ====
module tb_servo_loop_gain_bias_ff;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, position_mode;
  logic gain_switch_pin, gain_set_b, pctl_by_torque, pctl_by_speed;
  logic pctl_by_accel, pctl_by_deviation;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] speed_loop_gain, speed_loop_integ, position_loop_gain;
  logic [15:0] inertia_ratio;
  logic signed [31:0] deviation, cmd_rate, ff_cmd, expected_deviation;
  logic signed [15:0] bias_add;
  wire [3:0] pv = {pctl_by_deviation, pctl_by_accel, pctl_by_speed,
    pctl_by_torque};
  int n_errors = 0, n_compared = 0, cyc = 0, i;
  int unsigned s = 35, x;
  int m[12] = '{800, 2000, 400, 300, 800, 2000, 400, 0, 7, 0, 0, 4};
  int hi[12] = '{20000, 51200, 20000, 20000, 20000, 51200, 20000, 450,
    250, 100, 6400, 4};
  int dv[3] = '{8, 7, -20};
  int bx[3] = '{100, 0, -100};

  slg_servo_gain #(.FF_STEP_CYC(4)) slg_servo_gain_inst (.*);
  slg_host slg_host_inst (.*);

  // ==========================================================
  // Model and helpers
  function automatic int unsigned rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic int sat(int k, int v);
    int lo;
    lo = (k % 2 == 0 && k < 7) ? 10 : (k == 1 || k == 5) ? 15 : 0;
    if (k == 11)
      return (v & 'hfff0) | ((v & 15) > 4 ? 4 : v & 15);
    return v < lo ? lo : v > hi[k] ? hi[k] : v;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic w(input int k, input logic [15:0] v);
    slg_host_inst.wr(8'(k * 4), v, r);
    chk(32'(r), 0);
    m[k] = sat(k, int'(v));
  endtask
  task automatic rchk(input int k);
    slg_host_inst.rd(8'(k * 4), d, r);
    chk(d, m[k]);
    chk(32'(r), 0);
  endtask
  task automatic st;
    repeat (8) @(posedge clk);
  endtask
  task automatic finish_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_errors++;
      finish_test;
    end
  end

  // ==========================================================
  // Scenarios
  initial
  begin
    {srst, position_mode, gain_switch_pin} = 3'b100;
    deviation = 0;
    cmd_rate = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 12; i++)
      rchk(i);
    repeat (30)
    begin
      x = rnd();
      i = x % 12;
      slg_host_inst.stall = x[21:20];
      x = rnd();
      w(i, x[15:0]);
      rchk(i);
    end
    slg_host_inst.wr(8'h30, 16'h0001, r);
    chk(32'(r), 2);
    slg_host_inst.wr(8'h02, 16'h0001, r);
    chk(32'(r), 2);
    rchk(0);
    slg_host_inst.rd(8'h34, d, r);
    chk(d, 0);
    chk(32'(r), 2);
    w(4, 16'h04d2);
    w(6, 16'h0258);
    w(2, 16'h01f4);
    position_mode <= 1'b1;
    gain_switch_pin <= 1'b1;
    st;
    chk(speed_loop_gain, m[4]);
    chk(position_loop_gain, m[6]);
    chk(32'(gain_set_b), 1);
    chk(speed_loop_integ, m[5]);
    slg_host_inst.rd(8'h30, d, r);
    chk(d, 32'h0000000d);
    position_mode <= 1'b0;
    cmd_rate <= 5000;
    st;
    chk(speed_loop_gain, m[0]);
    chk(speed_loop_integ, m[1]);
    chk(expected_deviation, 50000 / m[2]);
    chk(inertia_ratio, m[3]);
    position_mode <= 1'b1;
    gain_switch_pin <= 1'b0;
    w(7, 0);
    w(7, 100);
    w(8, 7);
    for (i = 0; i < 3; i++)
    begin
      deviation <= dv[i];
      st;
      chk(bias_add, bx[i]);
    end
    w(10, 0);
    w(9, 50);
    cmd_rate <= 1000;
    st;
    chk(ff_cmd, 500);
    w(10, 3);
    cmd_rate <= 2000;
    repeat (3) @(posedge clk);
    chk(32'(ff_cmd < 700), 1);
    repeat (200) @(posedge clk);
    chk(32'(ff_cmd > 996), 1);
    for (i = 0; i < 5; i++)
    begin
      w(11, 16'(i));
      st;
      chk(pv, i < 4 ? 1 << i : 0);
    end
    position_mode <= 1'b0;
    w(11, 16'h0003);
    st;
    chk(pv, 0);
    finish_test;
  end
endmodule
